/* logic/sfpi_defines.vh */
// Constants for the serial flash pin front end
`ifndef SFPI_DEFINES_VH
`define SFPI_DEFINES_VH
// Register byte offsets on the Avalon-MM slave
`define SFPI_REG_CTRL 4'h0
`define SFPI_REG_STATUS 4'h4
`define SFPI_REG_PROT 4'h8
`define SFPI_REG_RXCMD 4'hC
// Control fields
`define SFPI_CTRL_QE 0
`define SFPI_CTRL_PINRST 1
`define SFPI_CTRL_LANES_LO 2
`define SFPI_CTRL_LANES_HI 3
`define SFPI_CTRL_DRIVE 4
`define SFPI_CTRL_RESET 32'h00000000
// Status fields
`define SFPI_ST_SEL 0
`define SFPI_ST_ARMED 1
`define SFPI_ST_PAUSE 2
`define SFPI_ST_BUSY 3
`define SFPI_ST_WP 4
`define SFPI_ST_SRWB 5
`define SFPI_ST_VALID 6
// Protection fields
`define SFPI_PROT_RESET 32'h00000000
// Lane widths
`define SFPI_LANES_1 2'h0
`define SFPI_LANES_2 2'h1
`define SFPI_LANES_4 2'h2
// Reset commands and timing
`define SFPI_CMD_RST_EN 8'h66
`define SFPI_CMD_RST 8'h99
`define SFPI_TRST_NS 30000
`define SFPI_CLK_NS 25
`define SFPI_TRST_CYC ((`SFPI_TRST_NS + `SFPI_CLK_NS - 1) / `SFPI_CLK_NS)
`define SFPI_THWRST_NS 1000
`define SFPI_THWRST_CYC ((`SFPI_THWRST_NS + `SFPI_CLK_NS - 1) / `SFPI_CLK_NS)
`endif

/* logic/sfpi_top.v */
// Serial flash pin front end: select, lanes, protect, pause and reset
//
// Local design decisions: the address map and the Avalon-MM register port.
`timescale 1ns/1ps
`include "sfpi_defines.vh"
module sfpi_top #(
  parameter TRST_CYCLES = `SFPI_TRST_CYC
) (
  input wire i_clock,
  input wire i_nrst,
  input wire i_select_n,
  input wire i_serial_clk,
  input wire [3:0] i_lane,
  input wire i_reset_pin_n,
  output reg [3:0] o_lane,
  output reg [3:0] o_lane_oe,
  output reg o_busy,
  input wire [3:0] i_avm_address,
  input wire i_avm_read,
  input wire i_avm_write,
  input wire [31:0] i_avm_writedata,
  output reg [31:0] o_avm_readdata,
  output reg o_avm_waitrequest
);
  // ==========================================================
  // Input synchronisers
  reg [7:0] sync1;
  reg [7:0] sync2;
  reg sck_d;
  reg sel_d;
  // Reset values match the idle pins so no false clock or select edge follows reset
  always @(posedge i_clock) begin
    if (!i_nrst) begin
      sync1 <= 8'hDF;
      sync2 <= 8'hDF;
      sck_d <= 1'b0;
      sel_d <= 1'b1;
    end else begin
      sync1 <= {i_reset_pin_n, i_select_n, i_serial_clk, 1'b1, i_lane};
      sync2 <= sync1;
      sck_d <= sync2[5];
      sel_d <= sync2[6];
    end
  end
  wire [3:0] lane_s = sync2[3:0];
  wire sck_s = sync2[5];
  wire sel_n_s = sync2[6];
  wire rstpin_s = sync2[7];
  wire sck_rise = sck_s & ~sck_d;
  wire sck_fall = ~sck_s & sck_d;
  wire sel_fall = ~sel_n_s & sel_d;
  wire sel_rise = sel_n_s & ~sel_d;

  // ==========================================================
  // Control registers
  reg [31:0] ctrl;
  reg [7:0] prot;
  wire qe = ctrl[`SFPI_CTRL_QE];
  wire pin_is_reset = ctrl[`SFPI_CTRL_PINRST];
  wire [1:0] lanes_sel = ctrl[`SFPI_CTRL_LANES_HI:`SFPI_CTRL_LANES_LO];
  wire drive_en = ctrl[`SFPI_CTRL_DRIVE];
  // Quad width falls back to single when quad enable is clear
  wire [1:0] lanes = (lanes_sel == `SFPI_LANES_4 && !qe) ? `SFPI_LANES_1 : lanes_sel;
  wire pause_func = !qe && !pin_is_reset;
  wire lane3_reset = !qe && pin_is_reset;

  // ==========================================================
  // Lane width helpers
  // Bits moved per sampled serial clock edge
  function [3:0] sfpi_lane_step;
    input [1:0] w;
    begin
      case (w)
        `SFPI_LANES_4: sfpi_lane_step = 4'h4;
        `SFPI_LANES_2: sfpi_lane_step = 4'h2;
        default: sfpi_lane_step = 4'h1;
      endcase
    end
  endfunction
  // Lanes driven back; single mode answers on io_lane_1 only
  function [3:0] sfpi_lane_mask;
    input [1:0] w;
    begin
      case (w)
        `SFPI_LANES_4: sfpi_lane_mask = 4'hF;
        `SFPI_LANES_2: sfpi_lane_mask = 4'h3;
        default: sfpi_lane_mask = 4'h2;
      endcase
    end
  endfunction

  // ==========================================================
  // Hardware reset from either pin, held only while the pin stays low, no minimum width check
  localparam [15:0] HWRST_CYC = `SFPI_THWRST_CYC;
  reg [15:0] hw_cnt;
  wire hw_low = !rstpin_s || (lane3_reset && !lane_s[3]);
  reg hw_reset;
  always @(posedge i_clock) begin
    if (!i_nrst) begin
      hw_cnt <= 16'h0000;
      hw_reset <= 1'b0;
    end else if (hw_low) begin
      // Shorter pulses are tolerated but only a full one is guaranteed
      if (hw_cnt != HWRST_CYC) hw_cnt <= hw_cnt + 16'h0001;
      hw_reset <= 1'b1;
    end else begin
      hw_cnt <= 16'h0000;
      hw_reset <= 1'b0;
    end
  end

  // ==========================================================
  // Pause tracking
  // A change waits for a low serial clock so a bit is never cut in half
  reg paused;
  reg pause_pend;
  reg next_paused;
  reg next_pause_pend;
  wire pause_in_n = pause_func ? lane_s[3] : 1'b1;
  wire pause_req = (pause_in_n == paused);
  always @* begin
    next_paused = paused;
    next_pause_pend = 1'b0;
    if (pause_req) begin
      if (!sck_s) begin
        next_paused = !pause_in_n;
      end else begin
        next_pause_pend = 1'b1;
      end
    end
    if (pause_pend && sck_fall) begin
      next_paused = !pause_in_n;
    end
  end
  always @(posedge i_clock) begin
    if (!i_nrst || hw_reset || sel_n_s) begin
      paused <= 1'b0;
      pause_pend <= 1'b0;
    end else begin
      paused <= next_paused;
      pause_pend <= next_pause_pend;
    end
  end
  wire active = !sel_n_s && !paused && !hw_reset;

  // ==========================================================
  // Shift engine
  reg armed;
  reg [7:0] shreg;
  reg [3:0] bitcnt;
  reg [7:0] last_cmd;
  reg cmd_valid;
  reg rst_en;
  reg [31:0] quiet;
  reg quiet_start;
  reg [7:0] tx;
  wire [3:0] step = sfpi_lane_step(lanes);
  reg [7:0] next_shreg;
  always @* begin
    case (lanes)
      `SFPI_LANES_4: next_shreg = {shreg[3:0], lane_s};
      `SFPI_LANES_2: next_shreg = {shreg[5:0], lane_s[1:0]};
      default: next_shreg = {shreg[6:0], lane_s[0]};
    endcase
  end
  always @(posedge i_clock) begin
    if (!i_nrst || hw_reset) begin
      armed <= 1'b0;
      shreg <= 8'h00;
      bitcnt <= 4'h0;
      last_cmd <= 8'h00;
      cmd_valid <= 1'b0;
      rst_en <= 1'b0;
      quiet_start <= 1'b0;
    end else begin
      quiet_start <= 1'b0;
      if (sel_fall) armed <= 1'b1;
      if (sel_rise) begin
        shreg <= 8'h00;
        bitcnt <= 4'h0;
      end else if (active && armed && quiet == 32'h00000000 && sck_rise) begin
        shreg <= next_shreg;
        if (bitcnt + step >= 4'h8) begin
          bitcnt <= 4'h0;
          last_cmd <= next_shreg;
          cmd_valid <= 1'b1;
          rst_en <= (next_shreg == `SFPI_CMD_RST_EN);
          if (rst_en && next_shreg == `SFPI_CMD_RST) quiet_start <= 1'b1;
        end else begin
          bitcnt <= bitcnt + step;
        end
      end
    end
  end

  // ==========================================================
  // Software reset quiet time
  // Commands stay locked out until the count has run down
  always @(posedge i_clock) begin
    if (!i_nrst || hw_reset) begin
      quiet <= 32'h00000000;
    end else if (quiet_start) begin
      quiet <= TRST_CYCLES;
    end else if (quiet != 32'h00000000) begin
      quiet <= quiet - 32'h00000001;
    end
  end

  // ==========================================================
  // Output lanes
  wire [3:0] oe_mask = sfpi_lane_mask(lanes);
  reg lane_on;
  always @(posedge i_clock) begin
    if (!i_nrst || hw_reset) begin
      o_lane <= 4'h0;
      o_lane_oe <= 4'h0;
      tx <= 8'h00;
      lane_on <= 1'b0;
      o_busy <= 1'b0;
    end else begin
      o_busy <= (quiet != 32'h00000000) || hw_reset;
      if (!active || !drive_en) begin
        o_lane_oe <= 4'h0;
        if (sel_n_s) begin
          tx <= last_cmd;
          lane_on <= 1'b0;
        end
      end else if (sck_fall) begin
        o_lane_oe <= oe_mask;
        case (lanes)
          `SFPI_LANES_4: begin
            o_lane <= tx[7:4];
            tx <= {tx[3:0], 4'h0};
          end
          `SFPI_LANES_2: begin
            o_lane <= {2'h0, tx[7:6]};
            tx <= {tx[5:0], 2'h0};
          end
          default: begin
            o_lane <= {2'h0, tx[7], 1'b0};
            tx <= {tx[6:0], 1'b0};
          end
        endcase
        lane_on <= 1'b1;
      end else if (lane_on) begin
        // After a pause the held bit is driven again, unchanged
        o_lane_oe <= oe_mask;
      end
    end
  end

  // ==========================================================
  // Write protection decode
  wire wp_n = qe ? 1'b1 : lane_s[2];
  wire lock0 = prot[6];
  wire srwb = lock0 && !wp_n;
  // Size in 4KB sectors or 256KB blocks
  function [23:0] sfpi_prot_size;
    input [7:0] p;
    begin
      if (p[2:0] == 3'h0) sfpi_prot_size = 24'h000000;
      else if (p[4]) sfpi_prot_size = 24'h001000 << (p[2:0] > 3'h3 ? 3'h2 : p[2:0] - 3'h1);
      else sfpi_prot_size = 24'h040000 << (p[2:0] - 3'h1);
    end
  endfunction
  wire [23:0] region = sfpi_prot_size(prot);

  // ==========================================================
  // Register write decode
  reg ack;
  reg [31:0] next_ctrl;
  reg [7:0] next_prot;
  reg [31:0] next_readdata;
  wire take = (i_avm_read || i_avm_write) && !ack;
  // A blocked protection write keeps the old value
  always @* begin
    next_ctrl = ctrl;
    next_prot = prot;
    if (i_avm_write) begin
      case (i_avm_address)
        `SFPI_REG_CTRL: next_ctrl = {27'h0, i_avm_writedata[4:0]};
        `SFPI_REG_PROT: if (!srwb) next_prot = i_avm_writedata[7:0];
        default: ;
      endcase
    end
  end

  // ==========================================================
  // Register read mux
  // Unmapped offsets read as zero
  always @* begin
    case (i_avm_address)
      `SFPI_REG_CTRL: next_readdata = ctrl;
      `SFPI_REG_STATUS: next_readdata = {25'h0, cmd_valid, srwb, !wp_n, o_busy, paused, armed,
        !sel_n_s};
      `SFPI_REG_PROT: next_readdata = {region, prot};
      `SFPI_REG_RXCMD: next_readdata = {24'h0, last_cmd};
      default: next_readdata = 32'h00000000;
    endcase
  end

  // ==========================================================
  // Avalon-MM slave: one wait cycle then answer
  // Read data is captured on the first edge; a write lands on the edge the master
  // sees waitrequest low, so both sides agree on when it took effect
  always @(posedge i_clock) begin
    if (!i_nrst) begin
      ctrl <= `SFPI_CTRL_RESET;
      prot <= 8'h00;
      o_avm_readdata <= 32'h00000000;
      o_avm_waitrequest <= 1'b1;
      ack <= 1'b0;
    end else begin
      ack <= take;
      o_avm_waitrequest <= !take;
      if (take) begin
        o_avm_readdata <= next_readdata;
      end
      if (ack) begin
        ctrl <= next_ctrl;
        prot <= next_prot;
      end
    end
  end
endmodule // sfpi_top

/* tb/sfpi_host.sv */
// Host controller model driving the flash pins in clock mode 0
`timescale 1ns/1ps
module sfpi_host (
  output logic o_select_n,
  output logic o_serial_clk,
  output logic [3:0] o_lane,
  input wire [3:0] i_lane
);
  initial begin
    o_select_n = 1'b1;
    o_serial_clk = 1'b0;
    o_lane = 4'hD;
  end
  // ====================
  // Frame: 200 ns clock only inside the frame, optional pause before bit hold_at
  task automatic frame(input logic [7:0] b, input int hold_at, output logic [7:0] r);
    #13 o_select_n = 1'b0;
    for (int i = 7; i >= 0; i--) begin
      if (i == hold_at) begin
        o_lane[3] = 1'b0;
        o_lane[0] = ~b[i];
        repeat (3) begin
          #100 o_serial_clk = 1'b1;
          #100 o_serial_clk = 1'b0;
        end
        #100 o_lane[3] = 1'b1;
      end
      o_lane[0] = b[i];
      o_lane[1] = ~b[i];
      #100 o_serial_clk = 1'b1;
      r[i] = i_lane[1];
      #100 o_serial_clk = 1'b0;
    end
    #100 o_select_n = 1'b1;
    // Released line shows the inverse rather than a stale bit
    o_lane[0] = ~o_lane[0];
  endtask
endmodule // sfpi_host

/* tb/sfpi_top_asserts.sv */
// Checker for the serial flash pin front end
`timescale 1ns/1ps
module sfpi_chk #(
  parameter TRST_CYCLES = 20
) (
  input wire i_clock,
  input wire i_nrst,
  input wire i_select_n,
  input wire i_serial_clk,
  input wire [3:0] i_lane,
  input wire i_reset_pin_n,
  input wire [3:0] o_lane,
  input wire [3:0] o_lane_oe,
  input wire o_busy,
  input wire [3:0] i_avm_address,
  input wire i_avm_read,
  input wire i_avm_write,
  input wire [31:0] i_avm_writedata,
  input wire [31:0] o_avm_readdata,
  input wire o_avm_waitrequest
);
  localparam int BUSY_MAX = 2 * TRST_CYCLES;
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_nrst);
  // ====================
  // Pins
  a_desel_float: assert property (i_select_n [*4] |-> o_lane_oe == 4'h0)
    else $error("lane driven while deselected");
  a_rstpin_float: assert property (!i_reset_pin_n [*5] |-> o_lane_oe == 4'h0)
    else $error("lane driven during reset pin");
  // Sync delay moves the change a few cycles past the pin fall, still inside the low phase
  a_out_on_fall: assert property ($changed(o_lane[1]) && o_lane_oe[1] && $past(o_lane_oe[1])
    |-> !i_serial_clk || !$past(i_serial_clk)) else $error("output changed off a fall");
  a_busy_hold: assert property ($rose(o_busy) |=> o_busy [*8])
    else $error("quiet time too short");
  a_busy_end: assert property ($rose(o_busy) |-> ##[1:BUSY_MAX] !o_busy)
    else $error("quiet time never ends");
  // ====================
  // Register bus
  a_ack_next: assert property ((i_avm_read || i_avm_write) && o_avm_waitrequest
    |=> !o_avm_waitrequest) else $error("no answer after one wait state");
  a_ack_single: assert property (!o_avm_waitrequest |=> o_avm_waitrequest)
    else $error("answer held too long");
  a_idle_wait: assert property (!(i_avm_read || i_avm_write) |=> o_avm_waitrequest)
    else $error("answer without request");
endmodule // sfpi_chk

bind sfpi_top sfpi_chk #(.TRST_CYCLES(TRST_CYCLES)) u_chk (.i_clock, .i_nrst, .i_select_n,
  .i_serial_clk, .i_lane, .i_reset_pin_n, .o_lane, .o_lane_oe, .o_busy, .i_avm_address,
  .i_avm_read, .i_avm_write, .i_avm_writedata, .o_avm_readdata, .o_avm_waitrequest);

/* tb/tb_sfpi_top.sv */
// Self-checking bench for the serial flash pin front end
`timescale 1ns/1ps
`include "sfpi_defines.vh"
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin mismatches++; \
  $display("BAD t=%0t got=%h exp=%h", $time, g, e); end end
module tb_sfpi_top;
  logic i_clock = 1'b0;
  logic i_nrst = 1'b0;
  logic i_reset_pin_n = 1'b1;
  logic [3:0] adr = 4'h0;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic wreq, busy, sel_n, sclk;
  logic [3:0] h_lane, d_lane, d_oe, pins;
  logic [31:0] exp_q[$];
  logic [7:0] echo, cmd;
  int mismatches = 0;
  int samples_checked = 0;
  always #12.5 i_clock = ~i_clock;
  assign pins = (d_oe & d_lane) | (~d_oe & h_lane);
  sfpi_top #(.TRST_CYCLES(20)) u_dut (.i_clock, .i_nrst, .i_select_n(sel_n),
    .i_serial_clk(sclk), .i_lane(pins), .i_reset_pin_n, .o_lane(d_lane), .o_lane_oe(d_oe),
    .o_busy(busy), .i_avm_address(adr), .i_avm_read(rd), .i_avm_write(wr),
    .i_avm_writedata(wdat), .o_avm_readdata(rdat), .o_avm_waitrequest(wreq));
  sfpi_host u_host (.o_select_n(sel_n), .o_serial_clk(sclk), .o_lane(h_lane), .i_lane(pins));
  // ====================
  // Bus master and result watcher
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge i_clock);
    adr <= a;
    wdat <= d;
    wr <= w;
    rd <= ~w;
    @(posedge i_clock);
    while (wreq) @(posedge i_clock);
    wr <= 1'b0;
    rd <= 1'b0;
  endtask
  task automatic rchk(input logic [3:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    bus(1'b0, a, 32'h0);
  endtask
  always @(posedge i_clock) begin
    if (rd && !wreq) `CHK(rdat, exp_q.pop_front())
  end
  task automatic report_and_stop();
    $display("checked %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    #200000;
    mismatches++;
    report_and_stop();
  end
  // ====================
  // Scenarios
  initial begin
    void'($urandom(32'hf3856279));
    repeat (10) @(posedge i_clock);
    i_nrst <= 1'b1;
    rchk(`SFPI_REG_CTRL, `SFPI_CTRL_RESET);
    rchk(`SFPI_REG_PROT, `SFPI_PROT_RESET);
    rchk(4'h2, 32'h0);
    cmd = 8'($urandom % 64);
    u_host.frame(cmd, -1, echo);
    rchk(`SFPI_REG_RXCMD, {24'h0, cmd});
    bus(1'b1, `SFPI_REG_CTRL, 32'h10);
    u_host.frame(8'hA5, 3, echo);
    // Each rise sees what the previous fall put out; the first rise sees the host's own line
    `CHK(echo, {1'b0, cmd[7:1]})
    rchk(`SFPI_REG_RXCMD, 32'hA5);
    bus(1'b1, `SFPI_REG_PROT, 32'h40);
    u_host.o_lane[2] = 1'b0;
    repeat (3) @(posedge i_clock);
    rchk(`SFPI_REG_STATUS, 32'h72);
    u_host.o_lane[2] = 1'b1;
    u_host.frame(`SFPI_CMD_RST_EN, -1, echo);
    u_host.frame(`SFPI_CMD_RST, -1, echo);
    repeat (6) @(posedge i_clock);
    `CHK(busy, 1'b1)
    while (busy) @(posedge i_clock);
    @(posedge i_clock);
    bus(1'b1, `SFPI_REG_CTRL, 32'h12);
    u_host.o_lane[3] = 1'b0;
    repeat (40) @(posedge i_clock);
    u_host.o_lane[3] = 1'b1;
    repeat (5) @(posedge i_clock);
    rchk(`SFPI_REG_RXCMD, 32'h0);
    u_host.frame(8'h3C, -1, echo);
    i_reset_pin_n <= 1'b0;
    repeat (40) @(posedge i_clock);
    i_reset_pin_n <= 1'b1;
    repeat (5) @(posedge i_clock);
    rchk(`SFPI_REG_STATUS, 32'h0);
    rchk(`SFPI_REG_RXCMD, 32'h0);
    report_and_stop();
  end
endmodule // tb_sfpi_top
